// file: include/zcspd_pkg.sv
package zcspd_pkg;

  // ----------------------------------------------------------------
  // Register map (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_ZC_SPEED = 4'h1;
  localparam logic [3:0] ADDR_MATCH_WIN = 4'h2;
  localparam logic [3:0] ADDR_DIV = 4'h3;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_POS = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;

  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_DIR_BIT = 4;
  localparam int unsigned CTRL_RESTART_BIT = 5;
  localparam logic [3:0] MODE_SPEED_ANALOG = 4'h0;
  localparam logic [3:0] MODE_POSITION = 4'h1;
  localparam logic [3:0] MODE_SPEED_ZCLAMP = 4'ha;
  localparam logic [3:0] CTRL_MODE_RST = 4'h0;
  localparam logic [11:0] ZC_SPEED_RST = 12'h00a;
  localparam logic [11:0] ZC_SPEED_MAX = 12'hbb8;
  localparam logic [6:0] MATCH_WIN_RST = 7'h0a;
  localparam logic [6:0] MATCH_WIN_MAX = 7'h64;
  localparam logic [14:0] DIV_RST = 15'h4000;
  localparam logic [14:0] DIV_MIN = 15'h0010;
  localparam logic [14:0] DIV_MAX = 15'h4000;
  localparam logic [31:0] HOLD_TOL = 32'h0000_0001;
  localparam logic [1:0] INDEX_VALID_REVS = 2'h2;

  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_CLAMP_ON = 0;
  localparam int unsigned IRQ_CLAMP_OFF = 1;
  localparam int unsigned IRQ_MATCH = 2;
  localparam int unsigned IRQ_INDEX = 3;

  // Synchronised pin slots and their reset levels
  localparam int unsigned PIN_ZC_EN = 0;
  localparam int unsigned PIN_A = 1;
  localparam int unsigned PIN_B = 2;
  localparam int unsigned PIN_Z = 3;
  localparam logic [3:0] PIN_RST = 4'h1;

  typedef enum logic [0:0] {
    ZC_FREE = 1'b0,
    ZC_HOLD = 1'b1
  } zcspd_zc_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } zcspd_bus_req_t;

  typedef struct packed {
    logic a;
    logic a_n;
    logic b;
    logic b_n;
    logic z;
    logic z_n;
  } zcspd_enc_out_t;

endpackage : zcspd_pkg

// file: rtl/zcspd_core.sv
`timescale 1ns/1ps
`default_nettype none

module zcspd_core #(
  parameter int unsigned ENC_COUNTS = 65536,
  parameter logic [11:0] MOTOR_MAX_RPM = 12'hbb8,
  parameter int unsigned POS_GAIN = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire zcspd_pkg::zcspd_bus_req_t bus_req_i,
  output logic [31:0] bus_rdata_o,
  input wire logic zero_clamp_enable_n_i,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic enc_index_i,
  input wire logic signed [15:0] speed_ref_i,
  input wire logic signed [15:0] speed_act_i,
  input wire logic position_done_n_i,
  output logic signed [15:0] speed_cmd_o,
  output logic clamp_active_o,
  output zcspd_pkg::zcspd_enc_out_t enc_out_o,
  output logic speed_match_n_o,
  output logic irq_o
);

  localparam int unsigned ACC_W = $clog2(ENC_COUNTS) + 2;
  localparam logic [ACC_W-1:0] ENC_CNT_L = ACC_W'(ENC_COUNTS);
  localparam logic signed [63:0] GAIN_S = 64'(POS_GAIN);
  localparam logic signed [63:0] MAX_S = 64'(MOTOR_MAX_RPM);

  if (ENC_COUNTS < 4 * 32'(zcspd_pkg::DIV_MAX) || POS_GAIN == 0 || MOTOR_MAX_RPM == 12'h000)
  begin : g_bad_cfg
    $error("zcspd_core: encoder counts too small or gain/max speed zero");
  end

  function automatic logic [31:0] abs32(input logic signed [31:0] v);
    abs32 = v[31] ? 32'(-v) : 32'(v);
  endfunction : abs32

  function automatic logic [31:0] clip_u(input logic [31:0] v, input logic [31:0] lo,
                                         input logic [31:0] hi);
    clip_u = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clip_u

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pins_w;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] pin_q;
  logic [3:0] pin_d;
  assign pins_w = {enc_index_i, enc_b_i, enc_a_i, zero_clamp_enable_n_i};
  // A change counts once the second and third stage agree
  assign pin_d = (s2_q & ~(s2_q ^ s3_q)) | (pin_q & (s2_q ^ s3_q));

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      s1_q <= zcspd_pkg::PIN_RST;
      s2_q <= zcspd_pkg::PIN_RST;
      s3_q <= zcspd_pkg::PIN_RST;
      pin_q <= zcspd_pkg::PIN_RST;
    end
    else
    begin
      s1_q <= pins_w;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
    end
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic [3:0] mode_q;
  logic dir_q;
  logic [11:0] zcs_q;
  logic [6:0] win_q;
  logic [14:0] div_cfg_q;
  logic [14:0] div_act_q;
  logic [3:0] stat_q;
  logic [3:0] mask_q;
  logic [3:0] stat_d;
  logic [3:0] ev_w;
  logic [31:0] rd_mux_w;
  logic [31:0] wd_w;
  logic wr_ctrl_w;
  logic wr_zcs_w;
  logic wr_win_w;
  logic wr_div_w;
  logic wr_istat_w;
  logic wr_mask_w;
  logic restart_w;
  assign wd_w = bus_req_i.wdata;
  assign wr_ctrl_w = bus_req_i.wr && bus_req_i.addr == zcspd_pkg::ADDR_CTRL;
  assign wr_zcs_w = bus_req_i.wr && bus_req_i.addr == zcspd_pkg::ADDR_ZC_SPEED;
  assign wr_win_w = bus_req_i.wr && bus_req_i.addr == zcspd_pkg::ADDR_MATCH_WIN;
  assign wr_div_w = bus_req_i.wr && bus_req_i.addr == zcspd_pkg::ADDR_DIV;
  assign wr_istat_w = bus_req_i.wr && bus_req_i.addr == zcspd_pkg::ADDR_IRQ_STAT;
  assign wr_mask_w = bus_req_i.wr && bus_req_i.addr == zcspd_pkg::ADDR_IRQ_MASK;
  assign restart_w = wr_ctrl_w && wd_w[zcspd_pkg::CTRL_RESTART_BIT];
  // Set wins over a same-cycle write-one clear
  assign stat_d = (stat_q & ~(wr_istat_w ? wd_w[3:0] : 4'h0)) | ev_w;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      mode_q <= zcspd_pkg::CTRL_MODE_RST;
      dir_q <= 1'b0;
      zcs_q <= zcspd_pkg::ZC_SPEED_RST;
      win_q <= zcspd_pkg::MATCH_WIN_RST;
      div_cfg_q <= zcspd_pkg::DIV_RST;
      div_act_q <= zcspd_pkg::DIV_RST;
      stat_q <= 4'h0;
      mask_q <= 4'h0;
    end
    else
    begin
      if (wr_ctrl_w)
      begin
        mode_q <= wd_w[zcspd_pkg::CTRL_MODE_LSB +: 4];
        dir_q <= wd_w[zcspd_pkg::CTRL_DIR_BIT];
      end
      if (wr_zcs_w)
      begin
        zcs_q <= 12'(clip_u(wd_w, 32'h0, 32'(zcspd_pkg::ZC_SPEED_MAX)));
      end
      if (wr_win_w)
      begin
        win_q <= 7'(clip_u(wd_w, 32'h0, 32'(zcspd_pkg::MATCH_WIN_MAX)));
      end
      if (wr_div_w)
      begin
        div_cfg_q <= 15'(clip_u(wd_w, 32'(zcspd_pkg::DIV_MIN), 32'(zcspd_pkg::DIV_MAX)));
      end
      if (restart_w)
      begin
        div_act_q <= div_cfg_q;
      end
      stat_q <= stat_d;
      if (wr_mask_w)
      begin
        mask_q <= wd_w[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Encoder decode and position
  // ----------------------------------------------------------------
  logic [1:0] ab_prev_q;
  logic [1:0] ab_bin_w;
  logic [1:0] step_w;
  logic enc_fwd_w;
  logic enc_rev_w;
  logic signed [31:0] pos_q;
  assign ab_bin_w = {pin_q[zcspd_pkg::PIN_A], pin_q[zcspd_pkg::PIN_A] ^ pin_q[zcspd_pkg::PIN_B]};
  assign step_w = ab_bin_w - ab_prev_q;
  assign enc_fwd_w = step_w == 2'h1;
  assign enc_rev_w = step_w == 2'h3;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      ab_prev_q <= 2'h0;
      pos_q <= 32'sh0;
    end
    else
    begin
      ab_prev_q <= ab_bin_w;
      pos_q <= pos_q + (enc_fwd_w ? 32'sh1 : (enc_rev_w ? -32'sh1 : 32'sh0));
    end
  end

  // ----------------------------------------------------------------
  // Zero clamp
  // ----------------------------------------------------------------
  zcspd_pkg::zcspd_zc_state_t zc_q;
  zcspd_pkg::zcspd_zc_state_t zc_d;
  logic [11:0] eff_thr_w;
  logic clamp_cond_w;
  logic signed [31:0] clamp_pos_q;
  logic signed [31:0] err_w;
  logic [31:0] err_abs_w;
  logic signed [63:0] prod_w;
  logic signed [15:0] loop_cmd_w;
  logic signed [15:0] pass_cmd_w;
  logic signed [15:0] cmd_d;
  assign eff_thr_w = (zcs_q > MOTOR_MAX_RPM) ? MOTOR_MAX_RPM : zcs_q;
  assign clamp_cond_w = !pin_q[zcspd_pkg::PIN_ZC_EN]
    && mode_q == zcspd_pkg::MODE_SPEED_ZCLAMP
    && abs32(32'(speed_ref_i)) < {20'h0, eff_thr_w};
  assign err_w = clamp_pos_q - pos_q;
  assign err_abs_w = abs32(err_w);
  assign prod_w = 64'(err_w) * GAIN_S;
  // Restoring command saturated to the motor maximum
  assign loop_cmd_w = (err_abs_w <= zcspd_pkg::HOLD_TOL) ? 16'sh0 :
    (prod_w > MAX_S) ? 16'(MAX_S) : ((prod_w < -MAX_S) ? 16'(-MAX_S) : 16'(prod_w));
  assign pass_cmd_w = dir_q ? 16'(-speed_ref_i) : speed_ref_i;
  assign cmd_d = (zc_q == zcspd_pkg::ZC_HOLD) ? loop_cmd_w : pass_cmd_w;

  always_comb
  begin
    zc_d = zc_q;
    case (zc_q)
      zcspd_pkg::ZC_FREE:
      begin
        if (clamp_cond_w)
        begin
          zc_d = zcspd_pkg::ZC_HOLD;
        end
      end
      zcspd_pkg::ZC_HOLD:
      begin
        if (!clamp_cond_w)
        begin
          zc_d = zcspd_pkg::ZC_FREE;
        end
      end
      default:
      begin
        zc_d = zcspd_pkg::ZC_FREE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      zc_q <= zcspd_pkg::ZC_FREE;
      clamp_pos_q <= 32'sh0;
      speed_cmd_o <= 16'sh0;
      clamp_active_o <= 1'b0;
    end
    else
    begin
      zc_q <= zc_d;
      if (zc_q == zcspd_pkg::ZC_FREE && zc_d == zcspd_pkg::ZC_HOLD)
      begin
        clamp_pos_q <= pos_q;
      end
      speed_cmd_o <= cmd_d;
      clamp_active_o <= zc_d == zcspd_pkg::ZC_HOLD;
    end
  end

  // ----------------------------------------------------------------
  // Encoder divider
  // ----------------------------------------------------------------
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] inc_w;
  logic [ACC_W-1:0] acc_up_w;
  logic up_wrap_w;
  logic dn_wrap_w;
  logic [1:0] oq_q;
  logic z_prev_q;
  logic idx_rise_w;
  logic [1:0] idx_cnt_q;
  assign inc_w = ACC_W'({div_act_q, 2'b00});
  assign acc_up_w = acc_q + inc_w;
  assign up_wrap_w = enc_fwd_w && acc_up_w >= ENC_CNT_L;
  assign dn_wrap_w = enc_rev_w && acc_q < inc_w;
  assign idx_rise_w = pin_q[zcspd_pkg::PIN_Z] && !z_prev_q;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i || restart_w)
    begin
      acc_q <= '0;
      oq_q <= 2'h0;
    end
    else
    begin
      // Raw shaft direction only, so phase order ignores dir_q
      if (up_wrap_w)
      begin
        acc_q <= acc_up_w - ENC_CNT_L;
        oq_q <= oq_q + 2'h1;
      end
      else if (enc_fwd_w)
      begin
        acc_q <= acc_up_w;
      end
      else if (dn_wrap_w)
      begin
        acc_q <= acc_q + ENC_CNT_L - inc_w;
        oq_q <= oq_q - 2'h1;
      end
      else if (enc_rev_w)
      begin
        acc_q <= acc_q - inc_w;
      end
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      enc_out_o <= '{a: 1'b0, a_n: 1'b1, b: 1'b0, b_n: 1'b1, z: 1'b0, z_n: 1'b1};
      z_prev_q <= 1'b0;
      idx_cnt_q <= 2'h0;
    end
    else
    begin
      enc_out_o.a <= oq_q[1];
      enc_out_o.a_n <= ~oq_q[1];
      enc_out_o.b <= oq_q[1] ^ oq_q[0];
      enc_out_o.b_n <= ~(oq_q[1] ^ oq_q[0]);
      enc_out_o.z <= pin_q[zcspd_pkg::PIN_Z];
      enc_out_o.z_n <= ~pin_q[zcspd_pkg::PIN_Z];
      z_prev_q <= pin_q[zcspd_pkg::PIN_Z];
      if (idx_rise_w && idx_cnt_q != zcspd_pkg::INDEX_VALID_REVS)
      begin
        idx_cnt_q <= idx_cnt_q + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Speed match, shared pin, interrupts, read data
  // ----------------------------------------------------------------
  logic match_w;
  logic match_q;
  logic is_pos_mode_w;
  assign match_w = abs32(32'(speed_ref_i) - 32'(speed_act_i)) < {25'h0, win_q};
  assign is_pos_mode_w = mode_q == zcspd_pkg::MODE_POSITION;
  assign ev_w = {idx_rise_w, match_w && !match_q,
                 zc_q == zcspd_pkg::ZC_HOLD && zc_d == zcspd_pkg::ZC_FREE,
                 zc_q == zcspd_pkg::ZC_FREE && zc_d == zcspd_pkg::ZC_HOLD};

  always_comb
  begin
    rd_mux_w = 32'h0;
    if (bus_req_i.addr == zcspd_pkg::ADDR_CTRL)
      rd_mux_w = {26'h0, 1'b0, dir_q, mode_q};
    else if (bus_req_i.addr == zcspd_pkg::ADDR_ZC_SPEED)
      rd_mux_w = {20'h0, zcs_q};
    else if (bus_req_i.addr == zcspd_pkg::ADDR_MATCH_WIN)
      rd_mux_w = {25'h0, win_q};
    else if (bus_req_i.addr == zcspd_pkg::ADDR_DIV)
      rd_mux_w = {17'h0, div_cfg_q};
    else if (bus_req_i.addr == zcspd_pkg::ADDR_STATUS)
      rd_mux_w = {1'b0, div_act_q, 12'h0,
                  idx_cnt_q == zcspd_pkg::INDEX_VALID_REVS, match_q,
                  zc_q == zcspd_pkg::ZC_HOLD, !pin_q[zcspd_pkg::PIN_ZC_EN]};
    else if (bus_req_i.addr == zcspd_pkg::ADDR_POS)
      rd_mux_w = pos_q;
    else if (bus_req_i.addr == zcspd_pkg::ADDR_IRQ_STAT)
      rd_mux_w = {28'h0, stat_q};
    else if (bus_req_i.addr == zcspd_pkg::ADDR_IRQ_MASK)
      rd_mux_w = {28'h0, mask_q};
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      match_q <= 1'b0;
      speed_match_n_o <= 1'b1;
      irq_o <= 1'b0;
      bus_rdata_o <= 32'h0;
    end
    else
    begin
      match_q <= match_w;
      speed_match_n_o <= is_pos_mode_w ? position_done_n_i : ~match_w;
      irq_o <= |(stat_d & mask_q);
      bus_rdata_o <= bus_req_i.rd ? rd_mux_w : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_mode_gate;
    mode_q != zcspd_pkg::MODE_SPEED_ZCLAMP |=> !clamp_active_o;
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("clamp outside clamp mode");

  property p_clamp_enter;
    zc_q == zcspd_pkg::ZC_FREE && clamp_cond_w |=> clamp_active_o && clamp_pos_q == $past(pos_q);
  endproperty
  a_clamp_enter: assert property (p_clamp_enter)
    else $error("clamp not entered");

  property p_hold_still;
    zc_q == zcspd_pkg::ZC_HOLD && err_abs_w <= 32'h1 |=> speed_cmd_o == 16'sh0;
  endproperty
  a_hold_still: assert property (p_hold_still)
    else $error("command inside hold band");

  property p_push_back;
    zc_q == zcspd_pkg::ZC_HOLD && err_w > 32'sh1 |=> speed_cmd_o > 16'sh0;
  endproperty
  a_push_back: assert property (p_push_back)
    else $error("no restoring command");

  property p_thr_cap;
    eff_thr_w <= MOTOR_MAX_RPM && (zcs_q > MOTOR_MAX_RPM || eff_thr_w == zcs_q);
  endproperty
  a_thr_cap: assert property (p_thr_cap)
    else $error("threshold cap wrong");

  property p_match;
    !is_pos_mode_w ##0 $stable(mode_q) |=> speed_match_n_o == !$past(match_w);
  endproperty
  a_match: assert property (p_match)
    else $error("speed match output wrong");

  property p_shared_pin;
    is_pos_mode_w |=> speed_match_n_o == $past(position_done_n_i);
  endproperty
  a_shared_pin: assert property (p_shared_pin)
    else $error("position done not routed");

  property p_pairs;
    enc_out_o.a_n == !enc_out_o.a && enc_out_o.b_n == !enc_out_o.b
      && enc_out_o.z_n == !enc_out_o.z;
  endproperty
  a_pairs: assert property (p_pairs)
    else $error("output pair not complementary");

  property p_div_range;
    (div_act_q >= zcspd_pkg::DIV_MIN && div_act_q <= zcspd_pkg::DIV_MAX)
      and (!restart_w |=> $stable(div_act_q));
  endproperty
  a_div_range: assert property (p_div_range)
    else $error("divide count changed early");

  property p_edge_cause;
    !restart_w ##1 oq_q != $past(oq_q) |-> $past(up_wrap_w || dn_wrap_w);
  endproperty
  a_edge_cause: assert property (p_edge_cause)
    else $error("output edge without wrap");

  c_clamp: cover property (zc_q == zcspd_pkg::ZC_FREE ##1 zc_q == zcspd_pkg::ZC_HOLD);
  c_match: cover property (!speed_match_n_o && !is_pos_mode_w);
  c_out_edge: cover property (up_wrap_w ##[1:20] dn_wrap_w);
  c_irq: cover property (irq_o);

endmodule : zcspd_core

`default_nettype wire

// file: verif/zcspd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Host: clamp pin, feedback count
// ------------------------------
module zcspd_host_model (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic clamp_req_i,
  input wire zcspd_pkg::zcspd_enc_out_t enc_out_i,
  output logic zero_clamp_enable_n_o,
  output logic signed [31:0] out_count_o,
  output logic index_ok_o
);
  logic [1:0] ab_q;
  logic [1:0] step_w;
  logic z_q;
  logic [1:0] revs_q;
  assign zero_clamp_enable_n_o = !clamp_req_i;
  assign step_w = {enc_out_i.a, enc_out_i.a ^ enc_out_i.b} - {ab_q[1], ^ab_q};
  // Zero point not trusted before two turns
  assign index_ok_o = revs_q == 2'h2;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      ab_q <= 2'h0;
      z_q <= 1'b0;
      revs_q <= 2'h0;
      out_count_o <= 32'sh0;
    end
    else
    begin
      ab_q <= {enc_out_i.a, enc_out_i.b};
      z_q <= enc_out_i.z;
      if (enc_out_i.z && !z_q && !index_ok_o)
        revs_q <= revs_q + 2'h1;
      if (step_w == 2'h1)
        out_count_o <= out_count_o + 32'sh1;
      if (step_w == 2'h3)
        out_count_o <= out_count_o - 32'sh1;
    end
  end
endmodule : zcspd_host_model
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  zcspd_pkg::zcspd_bus_req_t bus_req = '0;
  logic enc_a = 1'b0, enc_b = 1'b0, enc_idx = 1'b0, done_n = 1'b1, clamp_req = 1'b0;
  logic signed [15:0] sref = 16'sh0, sact = 16'sh0, cmd;
  logic clamp_on, match_n, irq, zc_en_n, idx_ok;
  zcspd_pkg::zcspd_enc_out_t eo;
  logic signed [31:0] host_cnt;
  logic [31:0] rdata, d;
  // Equal speeds out of reset raise the match event once
  logic [31:0] rexp [9] = '{32'h0, 32'ha, 32'ha, 32'h4000, 32'h0, 32'h0, 32'h4, 32'h0, 32'h0};
  int err_total = 0, checks = 0, ecnt = 0, w, dl, r;

  always #10 ref_clk_i = ~ref_clk_i;

  zcspd_core #(.ENC_COUNTS(65536), .MOTOR_MAX_RPM(12'h1f4), .POS_GAIN(4)) dut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .bus_req_i(bus_req),
    .bus_rdata_o(rdata), .zero_clamp_enable_n_i(zc_en_n), .enc_a_i(enc_a),
    .enc_b_i(enc_b), .enc_index_i(enc_idx), .speed_ref_i(sref),
    .speed_act_i(sact), .position_done_n_i(done_n), .speed_cmd_o(cmd),
    .clamp_active_o(clamp_on), .enc_out_o(eo), .speed_match_n_o(match_n), .irq_o(irq)
  );
  zcspd_host_model host (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .clamp_req_i(clamp_req), .enc_out_i(eo),
    .zero_clamp_enable_n_o(zc_en_n), .out_count_o(host_cnt), .index_ok_o(idx_ok)
  );

  // ------------------------------
  // Shared tasks
  // ------------------------------
  function automatic logic exp_match_n(input int dl, input int w);
    exp_match_n = (dl < 0 ? -dl : dl) >= w;
  endfunction : exp_match_n

  task finish_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: check %0d got %h exp %h", $time, checks, got, exp);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick

  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    bus_req.wr <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a);
    @(posedge ref_clk_i);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    bus_req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  // Quadrature counts, eight clocks apart
  task step(input int n);
    repeat (n < 0 ? -n : n)
    begin
      ecnt += n < 0 ? -1 : 1;
      @(posedge ref_clk_i);
      {enc_a, enc_b} <= {ecnt[1], ecnt[1] ^ ecnt[0]};
      repeat (7) @(posedge ref_clk_i);
    end
    #1;
  endtask : step

  task wait_clamp(input logic v);
    #1;
    for (int n = 0; n < 20 && clamp_on !== v; n++)
      tick(1);
    chk(clamp_on, v);
    if (clamp_on !== v)
      finish_test();
  endtask : wait_clamp

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial
  begin
    void'($urandom(40));
    repeat (10) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    tick(0);
    chk(eo, 6'h15);
    for (int i = 0; i < 9; i++)
    begin
      rd(4'(i));
      if (i != 4)
        chk(d, rexp[i]);
    end
    wr(4'h1, 32'hfa0);
    rd(4'h1);
    chk(d, 32'hbb8);
    wr(4'h2, 32'hc8);
    rd(4'h2);
    chk(d, 32'h64);
    wr(4'h3, 32'h5000);
    rd(4'h3);
    chk(d, 32'h4000);
    for (int i = 0; i < 30; i++)
    begin
      w = i == 0 ? 0 : i == 1 ? 100 : $urandom % 101;
      dl = i % 3 == 0 ? w : i % 3 == 1 ? 1 - w : int'($urandom % (2 * w + 7)) - w - 3;
      r = int'($urandom % 6001) - 3000;
      wr(4'h2, w);
      sref <= 16'(r);
      sact <= 16'(r + dl);
      tick(2);
      chk(match_n, exp_match_n(dl, w));
    end
    wr(4'h0, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      done_n <= k[0];
      sref <= 16'sd0;
      sact <= 16'sd500;
      tick(2);
      chk(match_n, k[0]);
      @(posedge ref_clk_i);
    end
    done_n <= 1'b0;
    wr(4'h0, 32'h0);
    tick(2);
    chk(match_n, 1'b1);
    @(posedge ref_clk_i);
    sref <= 16'sd5;
    clamp_req <= 1'b1;
    wr(4'h1, 32'ha);
    wr(4'h7, 32'h1);
    tick(8);
    chk(clamp_on, 1'b0);
    chk(cmd, 32'h5);
    wr(4'h0, 32'ha);
    wait_clamp(1'b1);
    @(posedge ref_clk_i);
    sref <= 16'sd8;
    tick(3);
    chk({cmd, irq}, 17'h1);
    step(1);
    chk(cmd, 32'h0);
    step(2);
    chk(cmd, -32'sd12);
    step(-3);
    chk(cmd, 32'h0);
    rd(4'h6);
    chk(d[1:0], 2'h1);
    wr(4'h6, 32'h1);
    tick(2);
    chk(irq, 1'b0);
    wr(4'h1, 32'h3);
    wait_clamp(1'b0);
    tick(2);
    chk(irq, 1'b0);
    wr(4'h1, 32'ha);
    wait_clamp(1'b1);
    @(posedge ref_clk_i);
    sref <= 16'sd20;
    wait_clamp(1'b0);
    tick(2);
    chk(cmd, 32'd20);
    wr(4'h1, 32'h7d0);
    sref <= 16'sd700;
    tick(8);
    chk(clamp_on, 1'b0);
    @(posedge ref_clk_i);
    sref <= -16'sd400;
    wait_clamp(1'b1);
    @(posedge ref_clk_i);
    clamp_req <= 1'b0;
    wait_clamp(1'b0);
    rd(4'h6);
    chk(d[1:0], 2'h3);
    wr(4'h6, 32'hf);
    step(5);
    chk(host_cnt, 32'h5);
    chk({eo.a_n, eo.b_n, eo.z_n}, 3'(~{eo.a, eo.b, eo.z}));
    chk(eo, 6'h19);
    rd(4'h5);
    chk(d, 32'h5);
    step(-5);
    chk(host_cnt, 32'h0);
    wr(4'h3, 32'h2000);
    rd(4'h4);
    chk(d[30:16], 15'h4000);
    wr(4'h0, 32'h30);
    rd(4'h4);
    chk(d[30:16], 15'h2000);
    step(8);
    chk(host_cnt, 32'h4);
    step(-8);
    chk(host_cnt, 32'h0);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge ref_clk_i);
      enc_idx <= 1'b1;
      tick(7);
      chk({eo.z, eo.z_n}, 2'h2);
      rd(4'h4);
      chk(d[3], k);
      @(posedge ref_clk_i);
      enc_idx <= 1'b0;
      tick(7);
    end
    chk(idx_ok, 1'b1);
    finish_test();
  end
endmodule : tb
`default_nettype wire
